// ===== rbr_cfg.v
// reclose blocking, inhibit, indication hold and retention settings
`default_nettype none
`include "rbr_cfg_defs.vh"

// Behaviour
// - shot-one block bits stop four initiation sources
// - shot-two/three block bits stop same sources
// - block only when one; all reset zero
// - shot-one stage bits suppress five stage trips
// - shot-two/three stage bits; all reset zero
// - stage blocking ends at cutout, reclaim, lockout
// - four inhibit bits, default set, disable reclose
// - fifth bit clears indications at close command
// - first indication held until hold timer expires
// - hold timer in minutes, default sixty
// - value 999 means manual clear only
// - hold timer touches display only
// - selector one retains indications and LEDs
// - selectors two-four retain recorder, events, counts
// - selector five keeps clock running; default 31
// - each selector written from panel or serial
// - all selectors clear disables battery supervision
// - checksum is sum of selected switch weights
module rbr_cfg #(
	parameter [31:0] MINUTE_CYCLES = `RBR_MINUTE_CYC,
	parameter        CODE_W        = 4
) (
	// clock, reset, enable
	input  wire              MCLK_I,
	input  wire              RST_I,
	input  wire              CE_I,
	// local operator panel settings write
	input  wire              PANEL_WR_I,
	input  wire [2:0]        PANEL_SEL_I,
	input  wire [9:0]        PANEL_DATA_I,
	// serial settings bus write
	input  wire              SER_WR_I,
	input  wire [2:0]        SER_SEL_I,
	input  wire [9:0]        SER_DATA_I,
	// settings readback
	input  wire [2:0]        RD_SEL_I,
	output reg  [9:0]        RD_DATA_O,
	// shot initiation
	input  wire [3:0]        INIT_SRC_I,
	input  wire              NEXT_SHOT1_I,
	output reg  [3:0]        INIT_ALLOW_O,
	// stage blocking during shots
	input  wire              SHOT_START_I,
	input  wire              SHOT_IS_FIRST_I,
	input  wire              CUTOUT_DONE_I,
	input  wire              RECLAIM_DONE_I,
	input  wire              LOCKOUT_I,
	input  wire [4:0]        STAGE_TRIP_I,
	output reg  [4:0]        STAGE_MASK_O,
	output reg  [4:0]        STAGE_TRIP_O,
	// reclose inhibit
	input  wire              INST_OC_TRIP_I,
	input  wire              HIGH_EF_TRIP_I,
	input  wire              THERMAL_ALARM_I,
	input  wire              PHASE_DISC_TRIP_I,
	input  wire              CB_CLOSE_CMD_I,
	output reg               AR_INHIBIT_O,
	output reg               IND_CLEAR_O,
	// trip indication display
	input  wire              NEW_TRIP_I,
	input  wire [CODE_W-1:0] TRIP_CODE_I,
	input  wire              MAN_CLEAR_I,
	output reg               SHOW_VALID_O,
	output reg  [CODE_W-1:0] SHOW_CODE_O,
	// retention selection
	output reg  [4:0]        RETAIN_O,
	output reg               BATT_SUPV_EN_O
);

	localparam [2:0] ST_EMPTY = 3'b001;
	localparam [2:0] ST_HOLD  = 3'b010;
	localparam [2:0] ST_FREE  = 3'b100;

	// settings select to one-hot write enable
	function [4:0] sel_dec;
		input [2:0] sel;
		begin
			case (sel)
				`RBR_SEL_SHOT_INIT:   sel_dec = 5'h01;
				`RBR_SEL_STAGE_BLOCK: sel_dec = 5'h02;
				`RBR_SEL_INHIBIT:     sel_dec = 5'h04;
				`RBR_SEL_HOLD_MIN:    sel_dec = 5'h08;
				`RBR_SEL_RETAIN:      sel_dec = 5'h10;
				default:              sel_dec = 5'h00;
			endcase
		end
	endfunction

	// hold values above 999 are out of range
	function hold_ok;
		input [9:0] val;
		begin
			hold_ok = (val <= `RBR_HOLD_MANUAL_ONLY);
		end
	endfunction

	reg  [7:0]        sib_q;
	reg  [7:0]        sib_d;
	reg  [9:0]        sbb_q;
	reg  [9:0]        sbb_d;
	reg  [4:0]        inh_q;
	reg  [4:0]        inh_d;
	reg  [9:0]        hold_q;
	reg  [9:0]        hold_d;
	reg  [4:0]        ret_q;
	reg  [4:0]        ret_d;
	reg  [4:0]        mask_d;
	reg  [2:0]        st_q;
	reg  [2:0]        st_d;
	reg  [CODE_W-1:0] code_d;
	reg               tmr_start;
	reg               clr_at_close;
	reg  [9:0]        rd_d;
	reg  [3:0]        init_blk;
	wire [4:0]        pan_we;
	wire [4:0]        ser_we;
	wire              tmr_done;
	wire [3:0]        init_ok;
	wire [3:0]        inh_src;
	wire [3:0]        inh_hit;
	wire [4:0]        mask_pick;
	wire [4:0]        trip_ok;
	wire              shot_end;
	wire              take_trip;
	genvar            g;

	assign pan_we = PANEL_WR_I ? sel_dec(PANEL_SEL_I) : 5'h00;
	assign ser_we = SER_WR_I ? sel_dec(SER_SEL_I) : 5'h00;

	// inhibit causes in switch order
	assign inh_src  = {PHASE_DISC_TRIP_I, THERMAL_ALARM_I, HIGH_EF_TRIP_I, INST_OC_TRIP_I};
	assign shot_end = CUTOUT_DONE_I | RECLAIM_DONE_I | LOCKOUT_I;

	// per-bit gating, one slice per source or stage
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_init
			// a source passes only while its block bit is zero
			assign init_ok[g] = INIT_SRC_I[g] & ~init_blk[g];
		end
		for (g = 0; g < 4; g = g + 1) begin : g_inh
			// an armed inhibit bit turns its cause into an inhibit
			assign inh_hit[g] = inh_src[g] & inh_q[g];
		end
		for (g = 0; g < 5; g = g + 1) begin : g_mask
			// block bits of the starting shot, first or later
			assign mask_pick[g] = SHOT_IS_FIRST_I ? sbb_q[`RBR_SBB_SHOT1_LO + g] : sbb_q[`RBR_SBB_SHOT23_LO + g];
		end
		for (g = 0; g < 5; g = g + 1) begin : g_trip
			// a stage trip is held back while its mask bit stands
			assign trip_ok[g] = STAGE_TRIP_I[g] & ~STAGE_MASK_O[g];
		end
	endgenerate

	// settings write, panel wins over serial in one cycle, except an out-of-range panel hold value
	always @* begin
		sib_d  = sib_q;
		sbb_d  = sbb_q;
		inh_d  = inh_q;
		hold_d = hold_q;
		ret_d  = ret_q;
		if (pan_we[0]) begin
			sib_d = PANEL_DATA_I[7:0];
		end else if (ser_we[0]) begin
			sib_d = SER_DATA_I[7:0];
		end
		if (pan_we[1]) begin
			sbb_d = PANEL_DATA_I;
		end else if (ser_we[1]) begin
			sbb_d = SER_DATA_I;
		end
		if (pan_we[2]) begin
			inh_d = PANEL_DATA_I[4:0];
		end else if (ser_we[2]) begin
			inh_d = SER_DATA_I[4:0];
		end
		// values above 999 are out of range and ignored
		if (pan_we[3] && hold_ok(PANEL_DATA_I)) begin
			hold_d = PANEL_DATA_I;
		end else if (ser_we[3] && hold_ok(SER_DATA_I)) begin
			hold_d = SER_DATA_I;
		end
		if (pan_we[4]) begin
			ret_d = PANEL_DATA_I[4:0];
		end else if (ser_we[4]) begin
			ret_d = SER_DATA_I[4:0];
		end
	end

	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			sib_q  <= `RBR_SHOT_INIT_RST;
			sbb_q  <= `RBR_STAGE_BLOCK_RST;
			inh_q  <= `RBR_INHIBIT_RST;
			hold_q <= `RBR_HOLD_RST;
			ret_q  <= `RBR_RETAIN_RST;
		end else if (CE_I) begin
			sib_q  <= sib_d;
			sbb_q  <= sbb_d;
			inh_q  <= inh_d;
			hold_q <= hold_d;
			ret_q  <= ret_d;
		end
	end

	// readback, value equals weighted checksum
	always @* begin
		case (RD_SEL_I)
			`RBR_SEL_SHOT_INIT:   rd_d = {2'b00, sib_q};
			`RBR_SEL_STAGE_BLOCK: rd_d = sbb_q;
			`RBR_SEL_INHIBIT:     rd_d = {5'h00, inh_q};
			`RBR_SEL_HOLD_MIN:    rd_d = hold_q;
			`RBR_SEL_RETAIN:      rd_d = {5'h00, ret_q};
			default:              rd_d = 10'h000;
		endcase
	end

	// initiation blocking by next shot number
	always @* begin
		if (NEXT_SHOT1_I) begin
			init_blk = sib_q[`RBR_SIB_SHOT1_LO +: 4];
		end else begin
			init_blk = sib_q[`RBR_SIB_SHOT23_LO +: 4];
		end
	end

	// stage mask latched at shot start, dropped at first end event
	always @* begin
		mask_d = STAGE_MASK_O;
		if (shot_end) begin
			mask_d = 5'h00;
		end
		if (SHOT_START_I) begin
			mask_d = mask_pick;
		end
	end

	always @* begin
		clr_at_close = CB_CLOSE_CMD_I & inh_q[`RBR_INH_CLR_AT_CLOSE];
	end

	// trip taken when nothing held, hold over, or clearing
	assign take_trip = NEW_TRIP_I & ((st_q != ST_HOLD) | tmr_done | MAN_CLEAR_I | clr_at_close);

	// trip indication display state
	always @* begin
		st_d      = st_q;
		code_d    = SHOW_CODE_O;
		tmr_start = 1'b0;
		case (st_q)
			ST_EMPTY: begin
				st_d = ST_EMPTY;
			end
			ST_HOLD: begin
				if (tmr_done) begin
					st_d = ST_FREE;
				end
			end
			ST_FREE: begin
				st_d = ST_FREE;
			end
			default: begin
				st_d = ST_EMPTY;
			end
		endcase
		if (MAN_CLEAR_I || clr_at_close) begin
			st_d = ST_EMPTY;
		end
		// a trip in the clearing cycle still shows
		if (take_trip) begin
			st_d      = ST_HOLD;
			code_d    = TRIP_CODE_I;
			tmr_start = 1'b1;
		end
	end

	rbr_hold_timer #(
		.MINUTE_CYCLES (MINUTE_CYCLES)
	) u_hold (
		.clk_i      (MCLK_I),
		.rst_i      (RST_I),
		.ce_i       (CE_I),
		.start_i    (tmr_start),
		.hold_min_i (hold_q),
		.done_o     (tmr_done)
	);

	// protection decisions, one cycle behind their inputs
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			INIT_ALLOW_O <= 4'h0;
			STAGE_MASK_O <= 5'h00;
			STAGE_TRIP_O <= 5'h00;
			AR_INHIBIT_O <= 1'b0;
			IND_CLEAR_O  <= 1'b0;
		end else if (CE_I) begin
			INIT_ALLOW_O <= init_ok;
			STAGE_MASK_O <= mask_d;
			STAGE_TRIP_O <= trip_ok;
			AR_INHIBIT_O <= |inh_hit;
			IND_CLEAR_O  <= clr_at_close | MAN_CLEAR_I;
		end
	end

	// trip indication display
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			st_q         <= ST_EMPTY;
			SHOW_VALID_O <= 1'b0;
			SHOW_CODE_O  <= {CODE_W{1'b0}};
		end else if (CE_I) begin
			st_q         <= st_d;
			SHOW_VALID_O <= (st_d != ST_EMPTY);
			SHOW_CODE_O  <= code_d;
		end
	end

	// settings readback
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			RD_DATA_O <= 10'h000;
		end else if (CE_I) begin
			RD_DATA_O <= rd_d;
		end
	end

	// retention selectors and battery supervision
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			RETAIN_O       <= `RBR_RETAIN_RST;
			BATT_SUPV_EN_O <= 1'b1;
		end else if (CE_I) begin
			RETAIN_O       <= ret_q;
			BATT_SUPV_EN_O <= (ret_q != 5'h00);
		end
	end

endmodule
`default_nettype wire

// ===== rbr_cfg_defs.vh
// constants for the reclose blocking and retention configuration block
`ifndef RBR_CFG_DEFS_VH
`define RBR_CFG_DEFS_VH

// setting select indices
`define RBR_SEL_SHOT_INIT    3'h0
`define RBR_SEL_STAGE_BLOCK  3'h1
`define RBR_SEL_INHIBIT      3'h2
`define RBR_SEL_HOLD_MIN     3'h3
`define RBR_SEL_RETAIN       3'h4

// widths
`define RBR_SHOT_INIT_W      8
`define RBR_STAGE_BLOCK_W    10
`define RBR_INHIBIT_W        5
`define RBR_HOLD_W           10
`define RBR_RETAIN_W         5

// reset values
`define RBR_SHOT_INIT_RST    8'h00
`define RBR_STAGE_BLOCK_RST  10'h000
`define RBR_INHIBIT_RST      5'h0f
`define RBR_HOLD_RST         10'h03c
`define RBR_RETAIN_RST       5'h1f

// field positions
`define RBR_SIB_SHOT1_LO     0
`define RBR_SIB_SHOT23_LO    4
`define RBR_SBB_SHOT1_LO     0
`define RBR_SBB_SHOT23_LO    5
`define RBR_INH_CLR_AT_CLOSE 4

// hold timer values
`define RBR_HOLD_MAX_TIMED   10'h3e6
`define RBR_HOLD_MANUAL_ONLY 10'h3e7

// timing
`define RBR_MINUTE_S         32'd60
`define RBR_CLK_HZ           32'd40000000
`define RBR_MINUTE_CYC       (`RBR_MINUTE_S * `RBR_CLK_HZ)

`endif

// ===== rbr_hold_timer.v
// indication hold timer counting whole minutes
`default_nettype none
`include "rbr_cfg_defs.vh"

module rbr_hold_timer #(
	parameter [31:0] MINUTE_CYCLES = `RBR_MINUTE_CYC
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        ce_i,
	// control
	input  wire        start_i,
	input  wire [9:0]  hold_min_i,
	// status
	output reg         done_o
);

	reg  [31:0] pre_q;
	reg  [9:0]  min_q;
	reg  [9:0]  lim_q;
	reg         run_q;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pre_q  <= 32'h0;
			min_q  <= 10'h000;
			lim_q  <= 10'h000;
			run_q  <= 1'b0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			if (start_i) begin
				// hold value latched at the trip itself
				pre_q <= 32'h0;
				min_q <= 10'h000;
				lim_q <= hold_min_i;
				run_q <= (hold_min_i != 10'h000);
				done_o <= (hold_min_i == 10'h000);
			end else if (run_q) begin
				if (lim_q == `RBR_HOLD_MANUAL_ONLY) begin
					done_o <= 1'b0;
				end else if (pre_q == MINUTE_CYCLES - 32'd1) begin
					pre_q <= 32'h0;
					if (min_q + 10'h001 == lim_q) begin
						run_q  <= 1'b0;
						done_o <= 1'b1;
					end else begin
						min_q <= min_q + 10'h001;
					end
				end else begin
					pre_q <= pre_q + 32'd1;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ===== rbr_cfg_props.sv
// assertion checker for the reclose settings block
`default_nettype none
`include "rbr_cfg_defs.vh"
module rbr_cfg_props #(
	parameter [31:0] MINUTE_CYCLES = `RBR_MINUTE_CYC,
	parameter        CODE_W        = 4
) (
	// clock, reset, settings
	input wire logic              MCLK_I, RST_I, PANEL_WR_I, SER_WR_I,
	input wire logic [2:0]        PANEL_SEL_I, RD_SEL_I,
	input wire logic [9:0]        PANEL_DATA_I, RD_DATA_O,
	// reclose and stage controls
	input wire logic [3:0]        INIT_SRC_I, INIT_ALLOW_O,
	input wire logic              SHOT_START_I, CUTOUT_DONE_I, RECLAIM_DONE_I, LOCKOUT_I,
	input wire logic [4:0]        STAGE_TRIP_I, STAGE_MASK_O, STAGE_TRIP_O, RETAIN_O,
	input wire logic              INST_OC_TRIP_I, HIGH_EF_TRIP_I, THERMAL_ALARM_I, PHASE_DISC_TRIP_I,
	input wire logic              CB_CLOSE_CMD_I, AR_INHIBIT_O, IND_CLEAR_O, BATT_SUPV_EN_O,
	// indication display
	input wire logic              NEW_TRIP_I, MAN_CLEAR_I, SHOW_VALID_O,
	input wire logic [CODE_W-1:0] SHOW_CODE_O, TRIP_CODE_I
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	sequence s_end;
		(CUTOUT_DONE_I || RECLAIM_DONE_I || LOCKOUT_I) && !SHOT_START_I;
	endsequence
	sequence s_quiet;
		SHOW_VALID_O && !NEW_TRIP_I && !MAN_CLEAR_I && !CB_CLOSE_CMD_I;
	endsequence
	sequence s_ret_write;
		PANEL_WR_I && PANEL_SEL_I == 3'h4 ##1 RD_SEL_I == 3'h4 && !PANEL_WR_I && !SER_WR_I;
	endsequence
	a_init_subset: assert property ((INIT_ALLOW_O & ~$past(INIT_SRC_I)) == 4'h0)
		else $error("initiation allowed without source");
	a_trip_masked: assert property ((STAGE_TRIP_O & ($past(STAGE_MASK_O) | ~$past(STAGE_TRIP_I))) == 5'h00)
		else $error("stage trip passed a block");
	a_mask_end: assert property (s_end |=> STAGE_MASK_O == 5'h00)
		else $error("stage block outlived its end");
	a_inhibit_cause: assert property (AR_INHIBIT_O |-> $past(INST_OC_TRIP_I || HIGH_EF_TRIP_I
		|| THERMAL_ALARM_I || PHASE_DISC_TRIP_I))
		else $error("inhibit without cause");
	a_clear_cause: assert property (IND_CLEAR_O |-> $past(CB_CLOSE_CMD_I || MAN_CLEAR_I))
		else $error("indication clear without cause");
	a_man_clear: assert property (MAN_CLEAR_I && !NEW_TRIP_I |=> IND_CLEAR_O && !SHOW_VALID_O)
		else $error("manual clear not applied");
	a_hold_keep: assert property (s_quiet |=> SHOW_VALID_O && $stable(SHOW_CODE_O))
		else $error("shown indication changed");
	a_trip_taken: assert property (NEW_TRIP_I && !SHOW_VALID_O |=> SHOW_VALID_O
		&& SHOW_CODE_O == $past(TRIP_CODE_I))
		else $error("trip on empty display not shown");
	a_batt_supv: assert property (BATT_SUPV_EN_O == (RETAIN_O != 5'h00))
		else $error("battery supervision wrong");
	a_ret_write: assert property (s_ret_write |=> RD_DATA_O == {5'h00, $past(PANEL_DATA_I[4:0], 2)}
		&& RETAIN_O == $past(PANEL_DATA_I[4:0], 2))
		else $error("retention write not seen");
	a_unmapped_rd: assert property (RD_SEL_I > 3'h4 |=> RD_DATA_O == 10'h000)
		else $error("unmapped readback not zero");
endmodule
bind rbr_cfg rbr_cfg_props #(
	.MINUTE_CYCLES (MINUTE_CYCLES),
	.CODE_W        (CODE_W)
) u_props (
	.MCLK_I            (MCLK_I),
	.RST_I             (RST_I),
	.PANEL_WR_I        (PANEL_WR_I),
	.SER_WR_I          (SER_WR_I),
	.PANEL_SEL_I       (PANEL_SEL_I),
	.RD_SEL_I          (RD_SEL_I),
	.PANEL_DATA_I      (PANEL_DATA_I),
	.RD_DATA_O         (RD_DATA_O),
	.INIT_SRC_I        (INIT_SRC_I),
	.INIT_ALLOW_O      (INIT_ALLOW_O),
	.SHOT_START_I      (SHOT_START_I),
	.CUTOUT_DONE_I     (CUTOUT_DONE_I),
	.RECLAIM_DONE_I    (RECLAIM_DONE_I),
	.LOCKOUT_I         (LOCKOUT_I),
	.STAGE_TRIP_I      (STAGE_TRIP_I),
	.STAGE_MASK_O      (STAGE_MASK_O),
	.STAGE_TRIP_O      (STAGE_TRIP_O),
	.RETAIN_O          (RETAIN_O),
	.INST_OC_TRIP_I    (INST_OC_TRIP_I),
	.HIGH_EF_TRIP_I    (HIGH_EF_TRIP_I),
	.THERMAL_ALARM_I   (THERMAL_ALARM_I),
	.PHASE_DISC_TRIP_I (PHASE_DISC_TRIP_I),
	.CB_CLOSE_CMD_I    (CB_CLOSE_CMD_I),
	.AR_INHIBIT_O      (AR_INHIBIT_O),
	.IND_CLEAR_O       (IND_CLEAR_O),
	.BATT_SUPV_EN_O    (BATT_SUPV_EN_O),
	.NEW_TRIP_I        (NEW_TRIP_I),
	.MAN_CLEAR_I       (MAN_CLEAR_I),
	.SHOW_VALID_O      (SHOW_VALID_O),
	.SHOW_CODE_O       (SHOW_CODE_O),
	.TRIP_CODE_I       (TRIP_CODE_I)
);
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the reclose settings block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, rst, pwr, swr, nxt1, sst, sfst, cut, rcl, lck, inst, hef, thm, pdc, cls, ntr, mcl;
	logic       inh, iclr, sval, batt;
	logic [2:0] psel, ssel, rsel;
	logic [9:0] pdat, sdat, rdat;
	logic [3:0] src, code, allow, scode;
	logic [4:0] strp, mask, trpo, ret;
	int         failures = 0;
	int         n_compared = 0;
	rbr_cfg #(.MINUTE_CYCLES(32'd10), .CODE_W(4)) dut (
		.MCLK_I(clk), .RST_I(rst), .CE_I(1'b1),
		.PANEL_WR_I(pwr), .PANEL_SEL_I(psel), .PANEL_DATA_I(pdat),
		.SER_WR_I(swr), .SER_SEL_I(ssel), .SER_DATA_I(sdat), .RD_SEL_I(rsel), .RD_DATA_O(rdat),
		.INIT_SRC_I(src), .NEXT_SHOT1_I(nxt1), .INIT_ALLOW_O(allow),
		.SHOT_START_I(sst), .SHOT_IS_FIRST_I(sfst), .CUTOUT_DONE_I(cut), .RECLAIM_DONE_I(rcl),
		.LOCKOUT_I(lck), .STAGE_TRIP_I(strp), .STAGE_MASK_O(mask), .STAGE_TRIP_O(trpo),
		.INST_OC_TRIP_I(inst), .HIGH_EF_TRIP_I(hef), .THERMAL_ALARM_I(thm), .PHASE_DISC_TRIP_I(pdc),
		.CB_CLOSE_CMD_I(cls), .AR_INHIBIT_O(inh), .IND_CLEAR_O(iclr), .NEW_TRIP_I(ntr),
		.TRIP_CODE_I(code), .MAN_CLEAR_I(mcl), .SHOW_VALID_O(sval), .SHOW_CODE_O(scode),
		.RETAIN_O(ret), .BATT_SUPV_EN_O(batt)
	);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one write strobe, panel or serial
	task automatic wr(input logic ser, input logic [2:0] sel, input logic [9:0] d);
		{swr, ssel, sdat} = {ser, sel, d};
		{pwr, psel, pdat} = {~ser, sel, d};
		cyc(1);
		{swr, pwr} = 2'b00;
	endtask
	task automatic rd(input logic [2:0] sel, input logic [9:0] exp);
		rsel = sel;
		cyc(1);
		chk(rdat, exp);
	endtask
	task automatic trip(input logic [3:0] c);
		{ntr, code} = {1'b1, c};
		cyc(1);
		ntr = 1'b0;
		cyc(1);
	endtask
	// shot start, gated trips, then one end condition
	task automatic shot(input logic f, input logic [4:0] m, input int e);
		{sst, sfst, strp} = {2'b10 | f, 5'h1f};
		cyc(1);
		sst = 1'b0;
		chk(mask, m);
		cyc(1);
		chk(trpo, ~m & 5'h1f);
		{cut, rcl, lck} = 3'b100 >> e;
		cyc(1);
		chk(mask, 5'h00);
		{cut, rcl, lck, strp} = 8'h00;
		cyc(1);
	endtask
	initial begin
		{pwr, swr, nxt1, sst, sfst, cut, rcl, lck, inst, hef, thm, pdc, cls, ntr, mcl} = '0;
		{psel, ssel, rsel, pdat, sdat, src, code, strp} = '0;
		rst = 1'b1;
		cyc(5);
		rst = 1'b0;
		chk(ret, 5'h1f);
		chk(batt, 1'b1);
		rd(0, 10'h000);
		rd(1, 10'h000);
		rd(2, 10'h00f);
		rd(3, 10'h03c);
		rd(4, 10'h01f);
		rd(5, 10'h000);
		wr(0, 0, 10'h05a);
		rd(0, 10'h05a);
		{src, nxt1} = 5'h1f;
		cyc(1);
		chk(allow, 4'h5);
		nxt1 = 1'b0;
		cyc(1);
		chk(allow, 4'ha);
		src = 4'h0;
		wr(1, 1, 10'h2a5);
		rd(1, 10'h2a5);
		for (int i = 0; i < 3; i++) shot(i != 1, (i == 1) ? 5'h15 : 5'h05, i);
		for (int i = 0; i < 4; i++) begin
			{inst, hef, thm, pdc} = 4'h8 >> i;
			cyc(1);
			chk(inh, 1'b1);
		end
		{inst, hef, thm, pdc} = 4'h0;
		cyc(1);
		chk(inh, 1'b0);
		wr(0, 3, 10'h001);
		trip(4'h3);
		trip(4'h5);
		chk(scode, 4'h3);
		chk(sval, 1'b1);
		cyc(14);
		trip(4'h5);
		chk(scode, 4'h5);
		wr(1, 3, 10'h3e7);
		rd(3, 10'h3e7);
		mcl = 1'b1;
		cyc(1);
		mcl = 1'b0;
		chk(iclr, 1'b1);
		chk(sval, 1'b0);
		trip(4'h7);
		cyc(20);
		trip(4'h9);
		chk(scode, 4'h7);
		wr(0, 3, 10'h3e8);
		rd(3, 10'h3e7);
		wr(1, 2, 10'h010);
		rd(2, 10'h010);
		{inst, hef, thm, pdc, cls, strp} = 10'h3ff;
		cyc(1);
		{inst, hef, thm, pdc, cls} = 5'h00;
		chk(inh, 1'b0);
		chk(iclr, 1'b1);
		chk(sval, 1'b0);
		chk(trpo, 5'h1f);
		strp = 5'h00;
		wr(1, 4, 10'h000);
		rd(4, 10'h000);
		chk(ret, 5'h00);
		chk(batt, 1'b0);
		for (int i = 0; i < 5; i++) begin
			wr(i[0], 4, 10'h001 << i);
			rd(4, 10'h001 << i);
			chk(ret, 5'h01 << i);
			chk(batt, 1'b1);
		end
		cyc(2);
		end_of_test();
	end
	// watchdog against a hung run
	initial begin
		cyc(5000);
		failures++;
		end_of_test();
	end
endmodule
`default_nettype wire
